// ---- logic/fsr_secreg.sv ----
// Functional notes
// (RULE1) Erase runs only if chip select rises right after the last address byte.
// (RULE2) Erase is ignored while the addressed register's lock bit is set.
// (RULE3) Address: top byte 00, bits 15..12 pick register 1-3, 11..9 zero.
// (RULE4) Host sends write enable before a security-register program.
// (RULE5) Program frame: opcode 42, three address bytes, at least one data byte.
// (RULE6) Chip select rising after a valid program frame starts a timed cycle.
// (RULE7) Write-in-progress reads 1 during the cycle and 0 once finished.
// (RULE8) Write enable latch clears before the timed cycle completes.
// (RULE9) Program is ignored while the lock bit is set.
// (RULE10) Read frame: opcode 48, three address bytes, one dummy; rising-edge sampling.
// (RULE11) Read data shifts out on falling edges from any starting byte.
// (RULE12) Read offset increments per byte, wraps 1FF to 000, runs until deselect.
// (RULE13) Accepted reset aborts operations and clears all volatile state.
// (RULE14) Reset needs a lone 66 frame followed by a lone 99 frame.
// (RULE15) Reset opcodes work in both clock polarity modes.
// (RULE16) All commands are refused during reset recovery.
// (RULE17) Host checks busy and suspend before issuing the reset pair.
// (RULE18) A fixed read-only 128-bit identifier no command can change.
// (RULE19) Unique ID frame: opcode 4B, four dummy bytes, then the identifier.
// (RULE20) Opcode 5A returns parameter-space bytes from the supplied address.
// (RULE21) Parameter read: opcode, 24-bit address, 8 dummy clocks, then data.
// (RULE22) Signature, revision 1.0 and header count 01 at bytes 00..06.
// (RULE23) First header: revision 1.0, length 09, table pointer 30.
// (RULE24) Second header: revision 1.0, length 03, table pointer 60.
`timescale 1ns/1ps

module fsr_link
  import fsr_pkg::*;
(
  // Serial link
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       rst_i,
  // From the command core
  input  wire logic       rd_active_i,
  input  wire logic [7:0] out_byte_i,
  // Events to the command core
  output logic            byte_tgl_o,
  output logic            part_tgl_o,
  output logic [2:0]      ev_idx_o,
  output logic [7:0]      ev_data_o,
  // Serial output
  output logic            so_o,
  output logic            so_oe_n_o
);

  fsr_rx_t rx_ff;
  fsr_rx_t nxt_rx;
  fsr_ev_t ev_ff;
  fsr_ev_t nxt_ev;
  fsr_tx_t tx_ff;
  fsr_tx_t nxt_tx;

  // Bits are taken on the rising edge in both clock modes
  always_comb begin
    nxt_rx      = rx_ff;
    nxt_rx.shin = {rx_ff.shin[5:0], si_i}; // RULE10
    nxt_rx.bits = rx_ff.bits + 3'h1;
    if (rx_ff.bits == BIT_LAST && rx_ff.idx != IDX_SAT) begin
      nxt_rx.idx = rx_ff.idx + 3'h1;
    end
  end

  // Frame state ends with the frame itself, so no edge after deselect is needed
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (rst_i || cs_n_i) begin
      rx_ff <= RX_IDLE;
    end else begin
      rx_ff <= nxt_rx;
    end
  end

  // Toggles survive deselect so the core never sees a false event
  always_comb begin
    nxt_ev = ev_ff;
    if (rx_ff.bits == BIT_LAST) begin
      nxt_ev.byte_tgl = ~ev_ff.byte_tgl;
      nxt_ev.ev_idx   = rx_ff.idx;
      nxt_ev.ev_data  = {rx_ff.shin, si_i};
    end
    if (rx_ff.bits == BIT_FIRST) begin
      nxt_ev.part_tgl = ~ev_ff.part_tgl;
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_ff <= EV_RESET;
    end else begin
      ev_ff <= nxt_ev;
    end
  end

  // Output byte is loaded on the falling edge right after a byte boundary
  always_comb begin
    nxt_tx     = tx_ff;
    nxt_tx.osh = {tx_ff.osh[6:0], 1'b0}; // RULE11
    if (rx_ff.bits == BIT_FIRST && rx_ff.idx >= IDX_OUT_FIRST) begin
      nxt_tx.osh  = out_byte_i; // RULE11
      nxt_tx.oe_n = ~rd_active_i;
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (rst_i || cs_n_i) begin
      tx_ff <= TX_IDLE;
    end else begin
      tx_ff <= nxt_tx;
    end
  end

  assign byte_tgl_o = ev_ff.byte_tgl;
  assign part_tgl_o = ev_ff.part_tgl;
  assign ev_idx_o   = ev_ff.ev_idx;
  assign ev_data_o  = ev_ff.ev_data;
  assign so_o       = tx_ff.osh[7];
  assign so_oe_n_o  = tx_ff.oe_n;

endmodule

module fsr_secreg
  import fsr_pkg::*;
#(
  parameter int unsigned PP_CYCLES = PP_CYC,
  parameter int unsigned SE_CYCLES = SE_CYC
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Serial link
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  output logic            so_o,
  output logic            so_oe_n_o,
  // Status
  input  wire logic [2:0] security_lock_bits_i,
  output logic            write_in_progress_o,
  output logic            write_enable_latch_o,
  output logic            soft_reset_o
);

  fsr_core_t   state_ff;
  fsr_core_t   nxt_state;
  logic [7:0]  sr_mem [0:SR_DEPTH-1] = '{default: ERASED_BYTE};
  logic        mem_we;
  logic [10:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        byte_tgl;
  logic        part_tgl;
  logic [2:0]  ev_idx;
  logic [7:0]  ev_data;
  logic        cs_fall;
  logic        cs_rise;
  logic        ev_byte;
  logic        ev_part;
  logic        lone_byte;
  logic        addr_ok;
  logic        locked;
  logic [1:0]  sel;

  fsr_link u_link (
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .si_i        (si_i),
    .rst_i       (rst_i),
    .rd_active_i (state_ff.rd_active),
    .out_byte_i  (state_ff.out_byte),
    .byte_tgl_o  (byte_tgl),
    .part_tgl_o  (part_tgl),
    .ev_idx_o    (ev_idx),
    .ev_data_o   (ev_data),
    .so_o        (so_o),
    .so_oe_n_o   (so_oe_n_o)
  );

  // Written only here; the erased start is a declaration value, not a process
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      sr_mem[mem_wa] <= mem_wd;
    end
  end

  // Edge detection looks only at the later synchroniser stages; the extra stage
  // keeps the output byte stable across the link's falling-edge load
  assign cs_fall = ~state_ff.cs_s[2] & state_ff.cs_s[3];
  assign cs_rise = state_ff.cs_s[2] & ~state_ff.cs_s[3];
  assign ev_byte = state_ff.evb_s[2] ^ state_ff.evb_s[3];
  assign ev_part = state_ff.evp_s[2] ^ state_ff.evp_s[3];

  always_comb begin
    nxt_state = state_ff;
    mem_we    = 1'b0;
    mem_wa    = '0;
    mem_wd    = ERASED_BYTE;
    nxt_state.cs_s     = {state_ff.cs_s[2:0], cs_n_i};
    nxt_state.evb_s    = {state_ff.evb_s[2:0], byte_tgl};
    nxt_state.evp_s    = {state_ff.evp_s[2:0], part_tgl};
    nxt_state.soft_rst = 1'b0;

    // Self-timed program, erase and reset recovery share one counter
    if (state_ff.busy || state_ff.rcv) begin
      if (state_ff.erasing && state_ff.ers_cnt != SR_ERASE_END) begin
        mem_we = 1'b1;
        mem_wa = {state_ff.ers_reg, state_ff.ers_cnt[8:0]};
        nxt_state.ers_cnt = state_ff.ers_cnt + 10'h1;
      end
      if (state_ff.cnt != 32'h0) begin
        nxt_state.cnt = state_ff.cnt - 32'h1;
      end else if (!state_ff.erasing || state_ff.ers_cnt == SR_ERASE_END) begin
        nxt_state.busy    = 1'b0; // RULE7
        nxt_state.erasing = 1'b0;
        nxt_state.rcv     = 1'b0;
      end
    end

    if (cs_fall) begin
      nxt_state.frame_ok  = ~state_ff.rcv; // RULE16
      nxt_state.got       = 1'b0;
      nxt_state.mid       = 1'b0;
      nxt_state.prog_ok   = 1'b0;
      nxt_state.wrote     = 1'b0;
      nxt_state.rd_active = 1'b0;
      nxt_state.last_idx  = IDX_OPCODE;
    end

    if (ev_part) begin
      nxt_state.mid = 1'b1;
    end

    if (ev_byte && state_ff.frame_ok) begin
      nxt_state.mid      = 1'b0;
      nxt_state.got      = 1'b1;
      nxt_state.last_idx = ev_idx;
      if (ev_idx == IDX_OPCODE) begin
        nxt_state.op = ev_data;
        if (ev_data == OP_UID_READ && !state_ff.busy) begin
          nxt_state.rd_active = 1'b1; // RULE19
          nxt_state.ptr       = 9'h000;
        end
      end else if (ev_idx <= IDX_ADDR_LAST) begin
        nxt_state.addr = {state_ff.addr[15:0], ev_data};
        if (ev_idx == IDX_ADDR_LAST) begin
          // Unique ID dummies in the address slots must not move the pointer set by the opcode
          if (state_ff.op != OP_UID_READ) begin
            nxt_state.ptr = nxt_state.addr[8:0]; // RULE11
          end
          if ((state_ff.op == OP_SR_READ || state_ff.op == OP_SFDP_READ) && !state_ff.busy) begin
            nxt_state.rd_active = 1'b1; // RULE20
          end
        end
      end else if (state_ff.op == OP_SR_PROG && state_ff.prog_ok) begin
        mem_we          = 1'b1;
        mem_wa          = {state_ff.addr[13:12] - 2'h1, state_ff.ptr};
        mem_wd          = sr_mem[mem_wa] & ev_data; // RULE5
        nxt_state.ptr   = state_ff.ptr + 9'h001;
        nxt_state.wrote = 1'b1;
      end else begin
        // Advancing from the dummy byte keeps the next byte one load ahead
        nxt_state.ptr = state_ff.ptr + 9'h001; // RULE12
      end
    end

    // Address checks use the freshest address so the last address byte counts
    addr_ok = nxt_state.addr[23:16] == SR_ADDR_HI && nxt_state.addr[11:9] == SR_GAP
           && nxt_state.addr[15:12] >= SR_SEL_FIRST && nxt_state.addr[15:12] <= SR_SEL_LAST; // RULE3
    sel     = nxt_state.addr[13:12] - 2'h1;
    locked  = security_lock_bits_i[sel];

    if (ev_byte && state_ff.frame_ok && ev_idx == IDX_ADDR_LAST && state_ff.op == OP_SR_PROG) begin
      nxt_state.prog_ok = state_ff.write_enable_latch && addr_ok && !locked && !state_ff.busy; // RULE9
    end

    // Next byte for the link; changes only after an event, well clear of its load
    nxt_state.out_byte = ERASED_BYTE;
    if (nxt_state.rd_active) begin
      case (nxt_state.op)
        OP_SR_READ: begin
          if (addr_ok) begin
            nxt_state.out_byte = sr_mem[{sel, nxt_state.ptr}]; // RULE11
          end
        end
        OP_SFDP_READ: begin // RULE21 RULE23 RULE24
          if (nxt_state.addr[23:9] == 15'h0000 && nxt_state.ptr < SFDP_LEN) begin
            nxt_state.out_byte = SFDP_HDR[{nxt_state.ptr[4:0], 3'b000} +: 8]; // RULE22
          end
        end
        OP_UID_READ: begin
          if (nxt_state.ptr < UID_BYTES) begin
            nxt_state.out_byte = UID_VALUE[{~nxt_state.ptr[3:0], 3'b000} +: 8]; // RULE18
          end
        end
        default: begin
          nxt_state.out_byte = ERASED_BYTE;
        end
      endcase
    end

    lone_byte = nxt_state.last_idx == IDX_OPCODE && !nxt_state.mid; // RULE14

    // Commands take effect when chip select rises
    if (cs_rise) begin
      nxt_state.rd_active = 1'b0;
      nxt_state.frame_ok  = 1'b0;
      if (state_ff.frame_ok && nxt_state.got) begin
        nxt_state.rst_en = 1'b0;
        case (nxt_state.op)
          OP_WRITE_ENABLE_COMMAND: begin
            if (lone_byte && !state_ff.busy) begin
              nxt_state.write_enable_latch = 1'b1;
            end
          end
          OP_WRDI: begin
            if (lone_byte && !state_ff.busy) begin
              nxt_state.write_enable_latch = 1'b0;
            end
          end
          OP_SR_PROG: begin
            if (nxt_state.wrote) begin
              nxt_state.busy = 1'b1; // RULE6
              nxt_state.cnt  = 32'(PP_CYCLES - 1);
              nxt_state.write_enable_latch  = 1'b0; // RULE8
            end
          end
          OP_SR_ERASE: begin
            if (nxt_state.last_idx == IDX_ADDR_LAST && !nxt_state.mid // RULE1
                && state_ff.write_enable_latch && addr_ok && !locked && !state_ff.busy) begin // RULE2
              nxt_state.busy    = 1'b1;
              nxt_state.erasing = 1'b1;
              nxt_state.ers_reg = sel;
              nxt_state.ers_cnt = 10'h000;
              nxt_state.cnt     = 32'(SE_CYCLES - 1);
              nxt_state.write_enable_latch     = 1'b0; // RULE8
            end
          end
          OP_RST_EN: begin
            nxt_state.rst_en = lone_byte; // RULE15
          end
          OP_RST: begin
            if (lone_byte && state_ff.rst_en) begin
              nxt_state.busy     = 1'b0; // RULE13
              nxt_state.erasing  = 1'b0;
              nxt_state.write_enable_latch      = 1'b0;
              nxt_state.soft_rst = 1'b1;
              nxt_state.rcv      = 1'b1; // RULE16
              nxt_state.cnt      = 32'(RST_CYC - 1);
            end
          end
          default: begin
            nxt_state.rst_en = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= CORE_INIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Program data lands during the frame; busy covers the timed cycle only
  assign write_in_progress_o  = state_ff.busy; // RULE7
  assign write_enable_latch_o = state_ff.write_enable_latch;
  assign soft_reset_o         = state_ff.soft_rst; // RULE13

endmodule

// ---- shared/fsr_pkg.sv ----
package fsr_pkg;

  // Opcodes handled by this block
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND      = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_SR_PROG   = 8'h42;
  localparam logic [7:0] OP_SR_ERASE  = 8'h44;
  localparam logic [7:0] OP_SR_READ   = 8'h48;
  localparam logic [7:0] OP_UID_READ  = 8'h4b;
  localparam logic [7:0] OP_SFDP_READ = 8'h5a;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;

  // Byte and bit positions inside a frame
  localparam logic [2:0] IDX_OPCODE    = 3'h0;
  localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
  localparam logic [2:0] IDX_OUT_FIRST = 3'h5;
  localparam logic [2:0] IDX_SAT       = 3'h7;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] BIT_FIRST     = 3'h0;

  // Security register address layout
  localparam logic [7:0] SR_ADDR_HI   = 8'h00;
  localparam logic [3:0] SR_SEL_FIRST = 4'h1;
  localparam logic [3:0] SR_SEL_LAST  = 4'h3;
  localparam logic [2:0] SR_GAP       = 3'h0;
  localparam int         SR_DEPTH     = 1536;
  localparam logic [9:0] SR_ERASE_END = 10'h200;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;

  // Read-only identity data; both values below are arbitrary
  localparam logic [7:0]   MAKER_CODE = 8'h5e;
  localparam logic [127:0] UID_VALUE  = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  localparam logic [8:0]   UID_BYTES  = 9'h010;
  localparam logic [8:0]   SFDP_LEN   = 9'h018;
  localparam logic [191:0] SFDP_HDR   = {
    8'hff, 8'h00, 8'h00, 8'h60, 8'h03, 8'h01, 8'h00, MAKER_CODE,
    8'hff, 8'h00, 8'h00, 8'h30, 8'h09, 8'h01, 8'h00, 8'h00,
    8'hff, 8'h01, 8'h01, 8'h00, 8'h50, 8'h44, 8'h46, 8'h53};

  // Self-timed cycles
  localparam int CLK_MHZ   = 125;
  localparam int T_PP_US   = 600;
  localparam int T_SE_US   = 300000;
  localparam int T_RST_US  = 30;
  localparam int PP_CYC    = T_PP_US * CLK_MHZ;
  localparam int SE_CYC    = T_SE_US * CLK_MHZ;
  localparam int RST_CYC   = T_RST_US * CLK_MHZ;

  // Link side state
  typedef struct packed {
    logic [2:0] bits;
    logic [2:0] idx;
    logic [6:0] shin;
  } fsr_rx_t;

  typedef struct packed {
    logic       byte_tgl;
    logic       part_tgl;
    logic [2:0] ev_idx;
    logic [7:0] ev_data;
  } fsr_ev_t;

  typedef struct packed {
    logic [7:0] osh;
    logic       oe_n;
  } fsr_tx_t;

  // Core side state
  typedef struct packed {
    logic [3:0]  cs_s;
    logic [3:0]  evb_s;
    logic [3:0]  evp_s;
    logic        frame_ok;
    logic [7:0]  op;
    logic [23:0] addr;
    logic        got;
    logic [2:0]  last_idx;
    logic        mid;
    logic        prog_ok;
    logic        wrote;
    logic [8:0]  ptr;
    logic        rd_active;
    logic [7:0]  out_byte;
    logic        write_enable_latch;
    logic        busy;
    logic        erasing;
    logic [1:0]  ers_reg;
    logic [9:0]  ers_cnt;
    logic [31:0] cnt;
    logic        rcv;
    logic        rst_en;
    logic        soft_rst;
  } fsr_core_t;

  localparam fsr_rx_t   RX_IDLE   = '0;
  localparam fsr_ev_t   EV_RESET  = '0;
  localparam fsr_tx_t   TX_IDLE   = '{osh: 8'h00, oe_n: 1'b1};
  localparam fsr_core_t CORE_INIT = '{cs_s: 4'hf, out_byte: 8'hff, default: '0};

endpackage

// ---- sim/fsr_secreg_monitor.sv ----
`timescale 1ns/1ps

module fsr_secreg_monitor
  import fsr_pkg::*;
#(
  parameter int unsigned PP_CYCLES = PP_CYC,
  parameter int unsigned SE_CYCLES = SE_CYC
) (
  // Core clock, reset and status
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] security_lock_bits_i,
  input  wire logic       write_in_progress_o,
  input  wire logic       write_enable_latch_o,
  input  wire logic       soft_reset_o,
  // Serial link
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       so_o,
  input  wire logic       so_oe_n_o
);
  logic [31:0] busy_ff;
  logic [11:0] rec_ff;
  logic [5:0]  edge_ff;

  always_ff @(posedge clock_i) begin
    busy_ff <= (rst_i || !write_in_progress_o) ? 32'h0 : busy_ff + 32'h1;
    if (rst_i)
      rec_ff <= 12'h0;
    else if (soft_reset_o)
      rec_ff <= 12'he74;
    else if (rec_ff != 12'h0)
      rec_ff <= rec_ff - 12'h1;
  end

  // Cleared by deselect, so a frame cut short never leaks its count
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i)
      edge_ff <= 6'h0;
    else if (edge_ff != 6'h3f)
      edge_ff <= edge_ff + 6'h1;
  end

  AST_OE_IDLE: assert property (@(posedge clock_i) disable iff (rst_i)
    cs_n_i && $past(cs_n_i) |-> so_oe_n_o) else $error("output driven while deselected");
  AST_OUT_LATE: assert property (@(negedge sclk_i) disable iff (rst_i)
    !so_oe_n_o |-> edge_ff >= 6'h29) else $error("output began before the dummy byte");
  AST_WIP_CS: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(write_in_progress_o) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("busy started inside a frame");
  AST_WIP_WEL: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(write_in_progress_o) |-> $past(write_enable_latch_o) || $past(write_enable_latch_o, 2))
    else $error("busy started without write enable");
  AST_WEL_CLR: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(write_in_progress_o) |-> ##[0:2] !write_enable_latch_o)
    else $error("write enable kept during timed cycle");
  AST_WIP_LEN: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(write_in_progress_o) |-> busy_ff inside {[PP_CYCLES:SE_CYCLES]}
    || soft_reset_o || $past(soft_reset_o)) else $error("busy length wrong");
  AST_RST_PULSE: assert property (@(posedge clock_i) disable iff (rst_i)
    soft_reset_o |=> !soft_reset_o) else $error("soft reset longer than one cycle");
  AST_RST_CLR: assert property (@(posedge clock_i) disable iff (rst_i)
    soft_reset_o |-> ##2 !write_in_progress_o && !write_enable_latch_o)
    else $error("soft reset left status set");
  AST_RECOVER: assert property (@(posedge clock_i) disable iff (rst_i)
    rec_ff != 12'h0 |-> !$rose(write_enable_latch_o) && !$rose(write_in_progress_o))
    else $error("command accepted during recovery");
  AST_WEL_SET: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(write_enable_latch_o) |-> cs_n_i && !write_in_progress_o)
    else $error("write enable set mid-frame or while busy");
endmodule

bind fsr_secreg fsr_secreg_monitor #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES))
  fsr_secreg_monitor_inst (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
  .security_lock_bits_i(security_lock_bits_i), .write_in_progress_o(write_in_progress_o),
  .write_enable_latch_o(write_enable_latch_o), .soft_reset_o(soft_reset_o));

// ---- sim/fsr_host_model.sv ----
`timescale 1ns/1ps

module fsr_host_model (
  // Link to the device
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  logic       mode3 = 1'b0;
  logic [7:0] rx_q[$];

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // Clock runs only inside frames; an undriven output reads as unknown
  task automatic xfer(input logic [7:0] tx[$], input int n_rx);
    logic [7:0] b;
    rx_q = {};
    #3;
    sclk_o = mode3;
    #10;
    cs_n_o = 1'b0;
    for (int i = 0; i < tx.size() + n_rx; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        sclk_o = 1'b0;
        si_o = b[k];
        #15;
        sclk_o = 1'b1;
        b[k] = so_oe_n_i ? 1'bx : so_i;
        #15;
      end
      if (i >= tx.size())
        rx_q.push_back(b);
    end
    sclk_o = mode3;
    #5;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #60;
  endtask
endmodule

// ---- sim/flash_secreg_reset_id_sfdp_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module flash_secreg_reset_id_sfdp_test
  import fsr_pkg::*;
;
  localparam int unsigned PP = 400;
  localparam int unsigned SE = 600;
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b0;
  logic [2:0] lock    = 3'h0;
  logic       sclk, cs_n, si, so, so_oe_n, write_in_progress, write_enable_latch, srst;
  logic [7:0] got[$];
  logic [7:0] sf[$];
  logic [31:0] bad[3] = '{32'h4400_4000, 32'h4401_1000, 32'h4400_1200};
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  int         n_rst      = 0;
  int         cyc        = 0;

  always #4 clock_i = ~clock_i;

  fsr_secreg #(.PP_CYCLES(PP), .SE_CYCLES(SE)) fsr_secreg_inst (
    .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_n_o(so_oe_n), .security_lock_bits_i(lock),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .soft_reset_o(srst));

  fsr_host_model fsr_host_model_inst (
    .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_n_i(so_oe_n));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hangs in the link end here; a stuck busy flag ends wait_idle after 2000 cycles instead
  always @(posedge clock_i) begin
    cyc++;
    if (srst === 1'b1)
      n_rst++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic run(input logic [7:0] tx[$], input int n_rx);
    fsr_host_model_inst.xfer(tx, n_rx);
    got = fsr_host_model_inst.rx_q;
    @(negedge clock_i);
  endtask

  task automatic expect_rx(input logic [7:0] exp[$]);
    for (int i = 0; i < exp.size(); i++)
      `CHK(got[i], exp[i])
  endtask

  task automatic wait_idle(input int unsigned lo, input int unsigned hi);
    int unsigned n;
    n = 0;
    while (write_in_progress === 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(n inside {[lo:hi]}, 1'b1)
  endtask

  initial begin
    sf = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
           8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
           MAKER_CODE, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
    // A real rising edge, so the link's asynchronous reset fires
    #1 rst_i = 1'b1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i) rst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    `CHK({write_in_progress, write_enable_latch, so_oe_n}, 3'b001)
    // Program across the end of register 1 and read back over the wrap
    run('{OP_WRITE_ENABLE_COMMAND}, 0);
    `CHK(write_enable_latch, 1'b1)
    run('{OP_SR_PROG, 8'h00, 8'h11, 8'hff, 8'h12, 8'h34, 8'h56}, 0);
    `CHK({write_in_progress, write_enable_latch}, 2'b10)
    wait_idle(PP - 8, PP);
    run('{OP_SR_READ, 8'h00, 8'h11, 8'hfe, 8'h00}, 4);
    expect_rx('{8'hff, 8'h12, 8'h34, 8'h56});
    @(negedge clock_i) lock = 3'h2;
    run('{OP_WRITE_ENABLE_COMMAND}, 0);
    run('{OP_SR_PROG, 8'h00, 8'h20, 8'h00, 8'h00}, 0);
    `CHK(write_in_progress, 1'b0)
    run('{OP_SR_ERASE, 8'h00, 8'h20, 8'h00}, 0);
    `CHK(write_in_progress, 1'b0)
    run('{OP_SR_READ, 8'h00, 8'h20, 8'h00, 8'h00}, 1);
    expect_rx('{8'hff});
    @(negedge clock_i) lock = 3'h0;
    foreach (bad[i]) begin
      run('{bad[i][31:24], bad[i][23:16], bad[i][15:8], bad[i][7:0]}, 0);
      `CHK(write_in_progress, 1'b0)
    end
    run('{OP_SR_ERASE, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
    `CHK(write_in_progress, 1'b0)
    run('{OP_WRITE_ENABLE_COMMAND}, 0);
    run('{OP_SR_ERASE, 8'h00, 8'h11, 8'h23}, 0);
    `CHK({write_in_progress, write_enable_latch}, 2'b10)
    wait_idle(SE - 8, SE);
    run('{OP_SR_READ, 8'h00, 8'h11, 8'hff, 8'h00}, 3);
    expect_rx('{8'hff, 8'hff, 8'hff});
    run('{OP_UID_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 16);
    for (int i = 0; i < 16; i++)
      `CHK(got[i], UID_VALUE[127 - 8 * i -: 8])
    run('{OP_SFDP_READ, 8'h00, 8'h00, 8'h00, 8'h00}, 24);
    expect_rx(sf);
    run('{OP_SFDP_READ, 8'h00, 8'h00, 8'h14, 8'h00}, 3);
    expect_rx('{8'h60, 8'h00, 8'h00});
    // Reset pair in the other clock mode, aborting a program in flight
    run('{OP_WRITE_ENABLE_COMMAND}, 0);
    run('{OP_SR_PROG, 8'h00, 8'h30, 8'h00, 8'h5a}, 0);
    fsr_host_model_inst.mode3 = 1'b1;
    run('{OP_RST}, 0);
    run('{OP_RST_EN, 8'h00}, 0);
    run('{OP_RST}, 0);
    `CHK({n_rst[3:0], write_in_progress}, 5'h01)
    run('{OP_RST_EN}, 0);
    run('{OP_RST}, 0);
    `CHK(n_rst[3:0], 4'h1)
    `CHK({write_in_progress, write_enable_latch}, 2'b00)
    run('{OP_WRITE_ENABLE_COMMAND}, 0);
    `CHK(write_enable_latch, 1'b0)
    fsr_host_model_inst.mode3 = 1'b0;
    repeat (RST_CYC) @(negedge clock_i);
    run('{OP_WRITE_ENABLE_COMMAND}, 0);
    `CHK(write_enable_latch, 1'b1)
    run('{OP_WRDI}, 0);
    run('{OP_SR_PROG, 8'h00, 8'h30, 8'h01, 8'h00}, 0);
    `CHK({write_in_progress, write_enable_latch}, 2'b00)
    print_verdict();
  end
endmodule
